/* File: hw/gpio_cfg_pkg.sv */
// Purpose: Shared constants for the serializer general-purpose pin block
// Assumes: 200 MHz core clock, 8-bit registers
// Notes:   Back-channel frame is 30 bit times long
package gpio_cfg_pkg;
  // Register offsets
  localparam logic [7:0] OFFS_PIN0_CFG    = 8'h0D;
  localparam logic [7:0] OFFS_PIN12_CFG   = 8'h0E;
  localparam logic [7:0] OFFS_PIN3_CFG    = 8'h0F;
  localparam logic [7:0] OFFS_REG56_CFG   = 8'h10;
  localparam logic [7:0] OFFS_REG78_CFG   = 8'h11;
  localparam logic [7:0] OFFS_STAT_LO     = 8'h1C;
  localparam logic [7:0] OFFS_STAT_HI     = 8'h1D;
  localparam int         NUM_CFG          = 5;
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [7:0] STAT_RESET       = 8'h00;
  // Status field positions
  localparam int         STAT_HI_PIN8_BIT = 0;
  localparam int         STAT_LO_REG5_BIT = 5;
  // Configuration nibble codes
  localparam logic [3:0] NIB_OUT_L        = 4'h1;
  localparam logic [3:0] NIB_OUT_H        = 4'h9;
  localparam logic [3:0] NIB_IN           = 4'h3;
  localparam logic [3:0] NIB_BC           = 4'h5;
  // High-speed channel modes chosen on the far end
  localparam logic [2:0] MODE_NORMAL      = 3'h0;
  localparam logic [2:0] MODE_FAST4       = 3'h3;
  localparam logic [2:0] MODE_FAST2       = 3'h2;
  localparam logic [2:0] MODE_FAST1       = 3'h1;
  localparam logic [3:0] SPF_NORMAL       = 4'h1;
  localparam logic [3:0] SPF_FAST4        = 4'h6;
  localparam logic [3:0] SPF_FAST2        = 4'hA;
  localparam logic [3:0] SPF_FAST1        = 4'hF;
  localparam int         BC_SAMPLE_W      = 24;
  // Frame timing: cycles per back-channel frame at each nominal rate
  localparam int         CLK_MHZ          = 200;
  localparam int         BC_FRAME_BITS    = 30;
  localparam int         BC_RATE_LO_MBPS  = 5;
  localparam int         BC_RATE_MID_MBPS = 10;
  localparam int         BC_RATE_HI_MBPS  = 20;
  localparam int         FRAME_CYC_LO     = BC_FRAME_BITS * CLK_MHZ / BC_RATE_LO_MBPS;
  localparam int         FRAME_CYC_MID    = BC_FRAME_BITS * CLK_MHZ / BC_RATE_MID_MBPS;
  localparam int         FRAME_CYC_HI     = BC_FRAME_BITS * CLK_MHZ / BC_RATE_HI_MBPS;
  localparam int         STEP_W           = 11;
endpackage

/* File: hw/bc_link_if.sv */
// Purpose: Carrier between the pin block and its back-channel replay unit
// Assumes: All signals on the core clock
// Notes:   Frame is a one-cycle strobe
`timescale 1ns/1ps
interface bc_link_if;
  logic        frame;
  logic [23:0] samples;
  logic [2:0]  mode;
  logic        rate_sel;
  logic        high_speed;
  logic [3:0]  pins;
  modport feed   (output frame, output samples, output mode, output rate_sel, output high_speed, input pins);
  modport replay (input frame, input samples, input mode, input rate_sel, input high_speed, output pins);
endinterface

/* File: hw/bc_replay.sv */
// Purpose: Spread the samples of one back-channel frame evenly over the frame
// Assumes: Frame strobe and payload arrive on the core clock
// Notes:   Sample k sits at bits [k*w +: w], w pins per sample
`timescale 1ns/1ps
module bc_replay (
  // Clock and reset
  input  wire logic  i_core_clk,
  input  wire logic  i_rst,
  // Frame data from the link
  bc_link_if.replay  bc
);
  import gpio_cfg_pkg::*;

  logic [23:0]       buf_q;
  logic [3:0]        left_q;
  logic [STEP_W-1:0] cnt_q;
  logic [2:0]        mode_q;
  logic [3:0]        pins_q;

  // Samples carried per frame; zero for modes that carry no pins
  function automatic logic [3:0] spf(input logic [2:0] m);
    case (m)
      MODE_NORMAL: spf = SPF_NORMAL;
      MODE_FAST4:  spf = SPF_FAST4;
      MODE_FAST2:  spf = SPF_FAST2;
      MODE_FAST1:  spf = SPF_FAST1;
      default:     spf = 4'h0;
    endcase
  endfunction

  // Cycles between samples; rounded down so every sample leaves before the next frame
  function automatic logic [STEP_W-1:0] step(input logic [2:0] m, input logic rs, input logic hs);
    int f;
    f = hs ? FRAME_CYC_HI : (rs ? FRAME_CYC_MID : FRAME_CYC_LO);
    case (m)
      MODE_FAST4: step = STEP_W'(f / 6);
      MODE_FAST2: step = STEP_W'(f / 10);
      MODE_FAST1: step = STEP_W'(f / 15);
      default:    step = STEP_W'(f);
    endcase
  endfunction

  // Apply the low sample of a buffer to the pins the mode allows
  function automatic logic [3:0] apply(input logic [2:0] m, input logic [3:0] p, input logic [23:0] b);
    case (m)
      MODE_FAST2: apply = {p[3:2], b[1:0]};
      MODE_FAST1: apply = {p[3:1], b[0]};
      default:    apply = b[3:0];
    endcase
  endfunction

  // Drop the sample just used
  function automatic logic [23:0] shift(input logic [2:0] m, input logic [23:0] b);
    case (m)
      MODE_FAST2: shift = b >> 2;
      MODE_FAST1: shift = b >> 1;
      default:    shift = b >> 4;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Replay sequencer; SPI modes carry no pins, so the pins hold their level
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      buf_q  <= '0;
      left_q <= '0;
      cnt_q  <= '0;
      mode_q <= MODE_NORMAL;
      pins_q <= '0;
    end else if (bc.frame && spf(bc.mode) != 4'h0) begin
      pins_q <= apply(bc.mode, pins_q, bc.samples);
      buf_q  <= shift(bc.mode, bc.samples);
      left_q <= spf(bc.mode) - 4'h1;
      cnt_q  <= step(bc.mode, bc.rate_sel, bc.high_speed) - STEP_W'(1);
      mode_q <= bc.mode;
    end else if (left_q != 4'h0) begin
      if (cnt_q == '0) begin
        pins_q <= apply(mode_q, pins_q, buf_q);
        buf_q  <= shift(mode_q, buf_q);
        left_q <= left_q - 4'h1;
        cnt_q  <= step(mode_q, bc.rate_sel, bc.high_speed) - STEP_W'(1);
      end else begin
        cnt_q <= cnt_q - STEP_W'(1);
      end
    end
  end

  assign bc.pins = pins_q;

  ////////////////////////////////////////////////////////////////////////////////
  property p_normal_first;
    @(posedge i_core_clk) disable iff (i_rst)
      bc.frame && bc.mode == MODE_NORMAL |=> pins_q == $past(bc.samples[3:0]);
  endproperty
  a_normal_first: assert property (p_normal_first) else $error("normal mode sample not applied");

  property p_fast1_pin0_only;
    @(posedge i_core_clk) disable iff (i_rst)
      bc.frame && bc.mode == MODE_FAST1 |=> pins_q[3:1] == $past(pins_q[3:1]) && pins_q[0] == $past(bc.samples[0]);
  endproperty
  a_fast1_pin0_only: assert property (p_fast1_pin0_only) else $error("single-pin mode touched other pins");

  property p_hi_rate_spacing;
    @(posedge i_core_clk) disable iff (i_rst)
      bc.frame && bc.mode == MODE_FAST1 && bc.high_speed |=> cnt_q == STEP_W'(19);
  endproperty
  a_hi_rate_spacing: assert property (p_hi_rate_spacing) else $error("sample spacing wrong at top rate");
endmodule

/* File: hw/serializer_gpio_config.sv */
// Purpose: Serializer general-purpose pins: four link-forwarded, four register-only
// Assumes: Register ports and link strobes run on i_core_clk; pins are asynchronous
// Notes:   Local register writes win over remote writes in the same cycle
`timescale 1ns/1ps
module serializer_gpio_config (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_power_down_input_n,
  // Local register access
  input  wire logic        i_loc_wr,
  input  wire logic        i_loc_rd,
  input  wire logic [7:0]  i_loc_addr,
  input  wire logic [7:0]  i_loc_wdata,
  output logic      [7:0]  o_loc_rdata,
  output logic             o_loc_rvalid,
  // Remote register access from the control channel
  input  wire logic        i_rem_wr,
  input  wire logic        i_rem_rd,
  input  wire logic [7:0]  i_rem_addr,
  input  wire logic [7:0]  i_rem_wdata,
  output logic      [7:0]  o_rem_rdata,
  output logic             o_rem_rvalid,
  // Forwarded pins 3..0
  input  wire logic [3:0]  i_gpio_i,
  output logic      [3:0]  o_gpio_o,
  output logic      [3:0]  o_gpio_oe,
  // Register-only pins 8..5 (index 3..0)
  input  wire logic [3:0]  i_regpin_i,
  output logic      [3:0]  o_regpin_o,
  output logic      [3:0]  o_regpin_oe,
  output logic      [3:0]  o_audio_data,
  // Link: forward pin levels out, back-channel frames in
  output logic      [3:0]  o_fwd_gpio,
  input  wire logic        i_bc_frame,
  input  wire logic [gpio_cfg_pkg::BC_SAMPLE_W-1:0] i_bc_samples,
  input  wire logic [2:0]  i_high_speed_channel_mode,
  input  wire logic        i_back_channel_rate_select,
  input  wire logic        i_back_channel_high_speed
);
  import gpio_cfg_pkg::*;

  logic [8:0] sync1_q;
  logic [8:0] sync2_q;
  logic       rst_all;
  logic [7:0] cfg_q [NUM_CFG];
  logic [3:0] pin_nib [4];
  logic [3:0] reg_nib [4];
  logic [7:0] stat_lo_q;
  logic [7:0] stat_hi_q;
  logic [3:0] gpio_o_q;
  logic [3:0] gpio_oe_q;
  logic [3:0] regpin_o_q;
  logic [3:0] regpin_oe_q;
  logic [3:0] audio_q;
  logic [3:0] fwd_q;
  bc_link_if  bc ();

  // Nibble decode shared by both pin groups: {drives, level}
  function automatic logic [1:0] drive(input logic [3:0] n);
    case (n)
      NIB_OUT_L: drive = 2'b10;
      NIB_OUT_H: drive = 2'b11;
      default:   drive = 2'b00;
    endcase
  endfunction

  // Register read mux, used by both access ports
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    rd_mux = 8'h00;
    if (a >= OFFS_PIN0_CFG && a <= OFFS_REG78_CFG) begin
      rd_mux = cfg_q[3'(a - OFFS_PIN0_CFG)];
    end else if (a == OFFS_STAT_LO) begin
      rd_mux = stat_lo_q;
    end else if (a == OFFS_STAT_HI) begin
      rd_mux = stat_hi_q;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers: {power-down, register-only pins, forwarded pins}
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_q <= 9'h1FF;
      sync2_q <= 9'h1FF;
    end else begin
      sync1_q <= {i_power_down_input_n, i_regpin_i, i_gpio_i};
      sync2_q <= sync1_q;
    end
  end

  // Power-down acts as a synchronous reset of the whole block except the input synchronisers
  assign rst_all = i_rst || !sync2_q[8];

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers; remote write applied, then a local write overrides
  for (genvar r = 0; r < NUM_CFG; r++) begin : g_cfg
    always_ff @(posedge i_core_clk) begin
      if (rst_all) begin
        cfg_q[r] <= CFG_RESET;
      end else if (i_loc_wr && i_loc_addr == OFFS_PIN0_CFG + 8'(r)) begin
        cfg_q[r] <= i_loc_wdata;
      end else if (i_rem_wr && i_rem_addr == OFFS_PIN0_CFG + 8'(r)) begin
        cfg_q[r] <= i_rem_wdata;
      end
    end
  end

  // Nibble placement per pin
  assign pin_nib[0] = cfg_q[0][3:0];
  assign pin_nib[1] = cfg_q[1][3:0];
  assign pin_nib[2] = cfg_q[1][7:4];
  assign pin_nib[3] = cfg_q[2][3:0];
  assign reg_nib[0] = cfg_q[3][3:0];
  assign reg_nib[1] = cfg_q[3][7:4];
  assign reg_nib[2] = cfg_q[4][3:0];
  assign reg_nib[3] = cfg_q[4][7:4];

  ////////////////////////////////////////////////////////////////////////////////
  // Read-data registers for both ports; status registers are read-only
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      o_loc_rdata  <= 8'h00;
      o_loc_rvalid <= 1'b0;
      o_rem_rdata  <= 8'h00;
      o_rem_rvalid <= 1'b0;
    end else begin
      o_loc_rvalid <= i_loc_rd;
      o_rem_rvalid <= i_rem_rd;
      if (i_loc_rd) begin
        o_loc_rdata <= rd_mux(i_loc_addr);
      end
      if (i_rem_rd) begin
        o_rem_rdata <= rd_mux(i_rem_addr);
      end
    end
  end

  // Input status from synchronised levels only, so reads never see a metastable bit
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      stat_lo_q <= STAT_RESET;
      stat_hi_q <= STAT_RESET;
    end else begin
      stat_lo_q <= {sync2_q[6:4], 1'b0, sync2_q[3:0]};
      stat_hi_q <= {7'h00, sync2_q[7]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Back-channel replay of remote samples
  assign bc.frame      = i_bc_frame;
  assign bc.samples    = i_bc_samples;
  assign bc.mode       = i_high_speed_channel_mode;
  assign bc.rate_sel   = i_back_channel_rate_select;
  assign bc.high_speed = i_back_channel_high_speed;

  bc_replay u_replay (
    .i_core_clk (i_core_clk),
    .i_rst      (rst_all),
    .bc         (bc.replay)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Forwarded pins: register drive, back-channel drive or forward sampling
  for (genvar p = 0; p < 4; p++) begin : g_fwd_pin
    // Decoded {drives, level} of this pin
    logic [1:0] drv;
    assign drv = drive(pin_nib[p]);
    always_ff @(posedge i_core_clk) begin
      if (rst_all) begin
        gpio_o_q[p]  <= 1'b0;
        gpio_oe_q[p] <= 1'b0;
        fwd_q[p]     <= 1'b0;
      end else begin
        if (pin_nib[p] == NIB_BC) begin
          gpio_oe_q[p] <= 1'b1;
          gpio_o_q[p]  <= bc.pins[p];
        end else begin
          gpio_oe_q[p] <= drv[1];
          gpio_o_q[p]  <= drv[0];
        end
        fwd_q[p] <= (pin_nib[p] == NIB_IN) && sync2_q[p];
      end
    end
  end

  // Register-only pins: no link path exists for these at all
  for (genvar q = 0; q < 4; q++) begin : g_reg_pin
    // Decoded {drives, level} of this pin
    logic [1:0] drv;
    assign drv = drive(reg_nib[q]);
    always_ff @(posedge i_core_clk) begin
      if (rst_all) begin
        regpin_o_q[q]  <= 1'b0;
        regpin_oe_q[q] <= 1'b0;
        audio_q[q]     <= 1'b0;
      end else begin
        regpin_oe_q[q] <= drv[1];
        regpin_o_q[q]  <= drv[0];
        // Output or input mode steals the shared pin; audio sees a quiet zero
        audio_q[q] <= (drv[1] || reg_nib[q] == NIB_IN) ? 1'b0 : sync2_q[q+4];
      end
    end
  end

  assign o_gpio_o     = gpio_o_q;
  assign o_gpio_oe    = gpio_oe_q;
  assign o_regpin_o   = regpin_o_q;
  assign o_regpin_oe  = regpin_oe_q;
  assign o_audio_data = audio_q;
  assign o_fwd_gpio   = fwd_q;

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_loc_out_h;
    i_loc_wr && i_loc_addr == OFFS_PIN0_CFG && i_loc_wdata == 8'h09;
  endsequence

  property p_out_high;
    @(posedge i_core_clk) disable iff (rst_all)
      s_loc_out_h ##1 !(i_loc_wr || i_rem_wr) |=> o_gpio_oe[0] && o_gpio_o[0];
  endproperty
  a_out_high: assert property (p_out_high) else $error("pin 0 not driven high");

  property p_loc_write;
    @(posedge i_core_clk) disable iff (rst_all)
      i_loc_wr && i_loc_addr == OFFS_REG78_CFG |=> cfg_q[4] == $past(i_loc_wdata);
  endproperty
  a_loc_write: assert property (p_loc_write) else $error("local config write lost");

  property p_rem_write;
    @(posedge i_core_clk) disable iff (rst_all)
      i_rem_wr && i_rem_addr == OFFS_REG56_CFG && !i_loc_wr |=> cfg_q[3] == $past(i_rem_wdata);
  endproperty
  a_rem_write: assert property (p_rem_write) else $error("remote config write lost");

  property p_stat_pin8;
    @(posedge i_core_clk) disable iff (rst_all)
      i_regpin_i[3] [*3] |=> stat_hi_q[STAT_HI_PIN8_BIT];
  endproperty
  a_stat_pin8: assert property (p_stat_pin8) else $error("pin 8 level not in status");

  property p_stat_pin0;
    @(posedge i_core_clk) disable iff (rst_all)
      !i_gpio_i[0] [*3] |=> !stat_lo_q[0];
  endproperty
  a_stat_pin0: assert property (p_stat_pin0) else $error("pin 0 low not in status");

  property p_fwd_only_input;
    @(posedge i_core_clk) disable iff (rst_all)
      o_fwd_gpio[2] |-> $past(pin_nib[2] == NIB_IN);
  endproperty
  a_fwd_only_input: assert property (p_fwd_only_input) else $error("forwarded pin sent while not input");

  property p_regpin_no_bc;
    @(posedge i_core_clk) disable iff (rst_all)
      reg_nib[1] == NIB_BC |=> !o_regpin_oe[1];
  endproperty
  a_regpin_no_bc: assert property (p_regpin_no_bc) else $error("register-only pin driven by link mode");

  property p_audio_taken;
    @(posedge i_core_clk) disable iff (rst_all)
      reg_nib[0] == NIB_IN |=> o_audio_data[0] == 1'b0;
  endproperty
  a_audio_taken: assert property (p_audio_taken) else $error("audio saw a pin in register mode");

  property p_power_down;
    @(posedge i_core_clk) disable iff (i_rst)
      !i_power_down_input_n [*3] |=> cfg_q[0] == CFG_RESET && cfg_q[4] == CFG_RESET && o_gpio_oe == 4'h0;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down did not reset registers");
endmodule

/* File: sim/bc_far_end.sv */
// Purpose: Far-end back-channel frame source for the pin block bench
// Assumes: Frames are launched just after a core clock rising edge
// Notes:   Payload is inverted once the strobe drops, so stale data is never usable
`timescale 1ns/1ps
module bc_far_end (
  // Clock
  input  wire logic        i_core_clk,
  // Back-channel frame towards the serializer
  output logic             o_frame,
  output logic      [23:0] o_samples,
  output logic      [2:0]  o_mode,
  output logic             o_rate_sel,
  output logic             o_high_speed
);
  ////////////////////////////////////////////////////////////////////////
  // Idle link: no frame, settings at the slowest rate
  initial begin
    o_frame      = 1'b0;
    o_samples    = 24'h000000;
    o_mode       = 3'h0;
    o_rate_sel   = 1'b0;
    o_high_speed = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // One frame: settings are levels that stay, payload is valid for the strobe only
  task automatic send(input logic [2:0] mode, input logic rs, input logic hs, input logic [23:0] s);
    @(posedge i_core_clk);
    o_mode       <= mode;
    o_rate_sel   <= rs;
    o_high_speed <= hs;
    o_samples    <= s;
    o_frame      <= 1'b1;
    @(posedge i_core_clk);
    o_frame      <= 1'b0;
    o_samples    <= ~s;
  endtask
endmodule

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the serializer pin block
// Assumes: Read data arrives within three cycles of the read strobe
// Notes:   Expected values come from a small register and pin model below
`timescale 1ns/1ps
module tb;
  import gpio_cfg_pkg::*;
  logic        clk;
  logic        rst;
  logic        pdn_n;
  logic        wr_s [2];
  logic        rd_s [2];
  logic [7:0]  addr_s [2];
  logic [7:0]  wd_s [2];
  logic [7:0]  rdat [2];
  logic        rv [2];
  logic [3:0]  gpio_i, reg_i, gpio_o, gpio_oe, reg_o, reg_oe, audio, fwd;
  logic        frame, rs, hs;
  logic [23:0] samp;
  logic [2:0]  mode;
  logic [7:0]  cfg [5];
  logic [31:0] seed = 32'hE2A49B8C;
  int          error_cnt = 0;
  int          checked = 0;
  int          cyc = 0;

  ////////////////////////////////////////////////////////////////////////
  // Design and far end; index 0 of the bus arrays is local, 1 is remote
  serializer_gpio_config u_dut (
    .i_core_clk(clk), .i_rst(rst), .i_power_down_input_n(pdn_n),
    .i_loc_wr(wr_s[0]), .i_loc_rd(rd_s[0]), .i_loc_addr(addr_s[0]), .i_loc_wdata(wd_s[0]),
    .o_loc_rdata(rdat[0]), .o_loc_rvalid(rv[0]),
    .i_rem_wr(wr_s[1]), .i_rem_rd(rd_s[1]), .i_rem_addr(addr_s[1]), .i_rem_wdata(wd_s[1]),
    .o_rem_rdata(rdat[1]), .o_rem_rvalid(rv[1]),
    .i_gpio_i(gpio_i), .o_gpio_o(gpio_o), .o_gpio_oe(gpio_oe),
    .i_regpin_i(reg_i), .o_regpin_o(reg_o), .o_regpin_oe(reg_oe), .o_audio_data(audio),
    .o_fwd_gpio(fwd), .i_bc_frame(frame), .i_bc_samples(samp), .i_high_speed_channel_mode(mode),
    .i_back_channel_rate_select(rs), .i_back_channel_high_speed(hs)
  );
  bc_far_end u_far (
    .i_core_clk(clk), .o_frame(frame), .o_samples(samp), .o_mode(mode),
    .o_rate_sel(rs), .o_high_speed(hs)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Legal nibbles plus 0x0, which leaves a pin idle
  function automatic logic [3:0] pick();
    logic [3:0] t [5] = '{NIB_OUT_L, NIB_OUT_H, NIB_IN, NIB_BC, 4'h0};
    return t[rnd() % 5];
  endfunction

  // Pin p: 0..3 forwarded pins, 4..7 register-only pins 5..8
  function automatic logic [3:0] nb(input int p);
    logic [7:0] c;
    c = cfg[p < 3 ? (p + 1) / 2 : (p == 3 ? 2 : p / 2 + 1)];
    return (p == 2 || (p > 3 && p % 2 == 1)) ? c[7:4] : c[3:0];
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One register access; the strobe drops at the edge that takes it
  task automatic acc(input int r, input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    wr_s[r] <= w;
    rd_s[r] <= !w;
    addr_s[r] <= a;
    wd_s[r] <= d;
    @(posedge clk);
    wr_s[r] <= 1'b0;
    rd_s[r] <= 1'b0;
    #1;
    q = 8'h00;
    for (int n = 0; n < 3 && !w && rv[r] !== 1'b1; n++) @(posedge clk) #1;
    if (!w) chk("rvalid", {7'h00, rv[r]}, 8'h01);
    if (!w) q = rdat[r];
  endtask

  task automatic rdchk(input int r, input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    acc(r, 1'b0, a, 8'h00, q);
    chk(nm, q, e);
  endtask

  // Pin outputs against the nibble model; driven levels only where a drive nibble is set
  task automatic check_pins();
    logic [3:0] n;
    logic       lv;
    logic [7:0] oe, ov, m, fw, au;
    for (int p = 0; p < 8; p++) begin
      n = nb(p);
      lv = p < 4 ? gpio_i[p] : reg_i[p - 4];
      m[p] = n == NIB_OUT_L || n == NIB_OUT_H;
      oe[p] = m[p] || (p < 4 && n == NIB_BC);
      ov[p] = n == NIB_OUT_H;
      fw[p] = n == NIB_IN ? lv : 1'b0;
      au[p] = (m[p] || n == NIB_IN) ? 1'b0 : lv;
    end
    chk("gpio_oe", {4'h0, gpio_oe}, {4'h0, oe[3:0]});
    chk("regpin_oe", {4'h0, reg_oe}, {4'h0, oe[7:4]});
    chk("pin_o", {reg_o, gpio_o} & m, ov & m);
    chk("fwd", {4'h0, fwd}, {4'h0, fw[3:0]});
    chk("audio", {4'h0, audio}, {4'h0, au[7:4]});
  endtask

  task automatic end_of_test();
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0]  q;
    logic [23:0] s;
    logic [3:0]  ex;
    int          st;
    static logic [2:0] md [5] = '{MODE_NORMAL, MODE_FAST4, MODE_FAST2, MODE_FAST1, 3'h6};
    static int         w [5] = '{4, 4, 2, 1, 0};
    static int         spf [5] = '{1, 6, 10, 15, 1};
    static logic       rsv [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
    static logic       hsv [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    rst = 1'b1;
    pdn_n = 1'b1;
    wr_s = '{1'b0, 1'b0};
    rd_s = '{1'b0, 1'b0};
    addr_s = '{8'h00, 8'h00};
    wd_s = '{8'h00, 8'h00};
    gpio_i = 4'h0;
    reg_i = 4'h0;
    foreach (cfg[i]) cfg[i] = CFG_RESET;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rdchk(i % 2, 8'(OFFS_PIN0_CFG + i), CFG_RESET, "cfg_rst");
    // Random nibbles written on one channel, read back on the other
    for (int it = 0; it < 10; it++) begin
      for (int i = 0; i < 5; i++) begin
        cfg[i] = {pick(), pick()};
        acc((it + i) % 2, 1'b1, 8'(OFFS_PIN0_CFG + i), cfg[i], q);
      end
      acc(it % 2, 1'b1, OFFS_STAT_LO, 8'hFF, q);
      @(posedge clk);
      gpio_i <= 4'(rnd());
      reg_i <= 4'(rnd());
      repeat (4) @(posedge clk);
      #1;
      check_pins();
      for (int i = 0; i < 5; i++) rdchk((it + i + 1) % 2, 8'(OFFS_PIN0_CFG + i), cfg[i], "cfg");
      rdchk(it % 2, OFFS_STAT_LO, {reg_i[2:0], 1'b0, gpio_i}, "stat_lo");
      rdchk(it % 2, OFFS_STAT_HI, {7'h00, reg_i[3]}, "stat_hi");
      rdchk(it % 2, 8'h20, 8'h00, "unmapped");
    end
    // Directed drive-high of pin 0 from the local port; random nibbles seldom hit it
    cfg[0] = 8'h09;
    acc(0, 1'b1, OFFS_PIN0_CFG, cfg[0], q);
    @(posedge clk);
    #1;
    check_pins();
    // Input path latency: old level after two edges, new level after three
    cfg[0] = {4'h0, NIB_IN};
    acc(0, 1'b1, OFFS_PIN0_CFG, cfg[0], q);
    repeat (3) @(posedge clk);
    gpio_i <= ~gpio_i;
    repeat (2) @(posedge clk);
    #1;
    chk("fwd_early", {7'h00, fwd[0]}, {7'h00, ~gpio_i[0]});
    @(posedge clk);
    #1;
    chk("fwd_sync", {7'h00, fwd[0]}, {7'h00, gpio_i[0]});
    // Back-channel replay in every mode and rate; the last frame is a non-pin mode
    for (int i = 0; i < 3; i++) begin
      cfg[i] = {NIB_BC, NIB_BC};
      acc(1, 1'b1, 8'(OFFS_PIN0_CFG + i), cfg[i], q);
    end
    for (int f = 0; f < 5; f++) begin
      s = 24'(rnd());
      st = BC_FRAME_BITS * CLK_MHZ / (hsv[f] ? 20 : (rsv[f] ? 10 : 5)) / spf[f];
      u_far.send(md[f], rsv[f], hsv[f], s);
      repeat (2 + st / 2) @(posedge clk);
      for (int k = 0; k < spf[f]; k++) begin
        for (int b = 0; b < w[f]; b++) ex[b] = s[k * w[f] + b];
        #1;
        chk("bc_pin", {4'h0, gpio_o}, {4'h0, ex});
        repeat (st) @(posedge clk);
      end
    end
    // Power-down returns every register to its default
    pdn_n <= 1'b0;
    repeat (4) @(posedge clk);
    pdn_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("oe_pd", {reg_oe, gpio_oe}, 8'h00);
    for (int i = 0; i < 5; i++) rdchk(i % 2, 8'(OFFS_PIN0_CFG + i), CFG_RESET, "cfg_pd");
    end_of_test();
  end
endmodule
